// >>> core/btm_exec.sv
// Execution unit for branch, skip, table read and misc instructions
// Assumes a register port master that never issues rd and wr together
`timescale 1ns/1ps
`include "btm_defines.svh"
// Function
// RULE1: Jump loads the program counter, takes two cycles, no flag change.
// RULE2: Skip-if-zero tests a byte, optional copy to acc, one or two cycles.
// RULE3: Bit tests skip on bit clear or bit set, one cycle plus skip.
// RULE4: Increment/decrement memory and skip on zero; skip and PC-low writes add cycles.
// RULE5: Accumulator forms put the result in acc and skip on zero.
// RULE6: Call jumps and saves the return address, two cycles, no flags.
// RULE7: Returns, including immediate and interrupt forms, take two cycles, no flags.
// RULE8: Current-page table read splits a word into memory and table-high, two cycles.
// RULE9: Last-page table read does the same from the final page, two cycles.
// RULE10: Writing the program-counter-low adds one instruction cycle.
// RULE11: A taken skip adds one instruction cycle.
// RULE12: No-op idles; clear and set force a byte to zero or ones.
// RULE13: Watchdog clear clears counter, time-out and power-down flags.
// RULE14: Two pre-clears together clear watchdog and flags; alone they change nothing.
// RULE15: Nibble swap in place or into the accumulator, no flags.
// RULE16: Power-down enters halt in one cycle and updates both flags.
// RULE17: Bit index from zero to seven picks a bit of a byte.
// RULE18: Branch, skip, call and return leave all flags alone.
// RULE19: Halt keeps state, clears watchdog, sets power-down, clears time-out.
// RULE20: The word after a taken skip is discarded without effect.
module btm_exec
  import btm_pkg::*;
#(
  parameter int STK_DEPTH = 4,
  parameter int PM_W = 15,
  parameter int WDG_W = 8
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  output logic busy,
  output logic halted
);
  localparam int SPW = $clog2(STK_DEPTH);

  logic [7:0] acc_q, acc_d;
  logic [11:0] pc_q, pc_d, paddr_q, paddr_d;
  logic [PM_W-9:0] thb_q, thb_d;
  logic to_q, to_d, pdn_q, pdn_d, halt_q, halt_d, busy_q, busy_d;
  logic skip_q, skip_d, pre1_q, pre1_d, pre2_q, pre2_d;
  logic [3:0] cnt_q, cnt_d;
  logic [1:0] ph_q, ph_d;
  logic [WDG_W-1:0] wdg_q, wdg_d;
  logic [SPW-1:0] sp_q, sp_d;
  logic [6:0] daddr_q, daddr_d, dm_wa;
  logic [31:0] rdata_q, rdata_d;
  logic [7:0] dmem [128];
  logic [PM_W-1:0] pmem [4096];
  logic [11:0] stk [STK_DEPTH];
  logic [7:0] mv, inc, dec, dm_wd;
  logic [PM_W-1:0] tword;
  logic [1:0] ncyc;
  logic dm_we, pm_we, stk_we, acc_cmd, issue, take, tick, ovf, pc_low_w;
  btm_instr_s ins;

  // ----------------------------------------
  // Decode helpers
  // ----------------------------------------
  function automatic logic wdg_clearing(input btm_op_e op, input logic p1, input logic p2);
    return op == OP_CWDT || (op == OP_CWD1 && p2) || (op == OP_CWD2 && p1);
  endfunction : wdg_clearing

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    ins = btm_instr_s'(wdata);
    mv = dmem[ins.mad];
    inc = mv + 8'h01;
    dec = mv - 8'h01;
    tword = pmem[(ins.op == OP_TRL) ? {`BTM_LAST_PAGE, acc_q} : {pc_q[11:8], acc_q}];
    tick = ph_q == 2'(`BTM_CPI - 1);
    ovf = tick && (&wdg_q);
    acc_cmd = wr && addr == `BTM_REG_INSTR && !busy_q && !halt_q;
    issue = acc_cmd && !skip_q;
    acc_d = acc_q;
    pc_d = pc_q;
    thb_d = thb_q;
    to_d = to_q; // RULE18
    pdn_d = pdn_q;
    halt_d = halt_q;
    skip_d = skip_q;
    pre1_d = pre1_q;
    pre2_d = pre2_q;
    sp_d = sp_q;
    daddr_d = daddr_q;
    paddr_d = paddr_q;
    ph_d = tick ? 2'h0 : ph_q + 2'h1;
    wdg_d = tick ? wdg_q + 1'b1 : wdg_q;
    cnt_d = (cnt_q != 4'h0) ? cnt_q - 4'h1 : 4'h0;
    take = 1'b0;
    ncyc = 2'h1;
    dm_we = 1'b0;
    dm_wa = ins.mad;
    dm_wd = 8'h00;
    pm_we = 1'b0;
    stk_we = 1'b0;
    pc_low_w = 1'b0;
    if (acc_cmd && skip_q) begin
      skip_d = 1'b0; // RULE20
    end
    if (issue) begin
      pc_d = pc_q + 12'h001;
      case (ins.op)
        OP_UNCONDITIONAL_BRANCH: begin
          pc_d = ins.tgt; // RULE1
          ncyc = 2'h2;
        end
        OP_CALL: begin
          stk_we = 1'b1; // RULE6
          sp_d = sp_q + 1'b1;
          pc_d = ins.tgt;
          ncyc = 2'h2;
        end
        OP_SUBROUTINE_EXIT, OP_RETA, OP_INTERRUPT_EXIT: begin
          pc_d = stk[sp_q - 1'b1]; // RULE7
          sp_d = sp_q - 1'b1;
          ncyc = 2'h2;
          if (ins.op == OP_RETA) begin
            acc_d = ins.tgt[7:0];
          end
        end
        OP_SKIP_IF_ZERO: take = mv == 8'h00; // RULE2
        OP_SKIP_IF_ZERO_TO_ACC: begin
          acc_d = mv; // RULE2
          take = mv == 8'h00;
        end
        OP_SZB: take = !mv[ins.bsel]; // RULE3 RULE17
        OP_SKIP_IF_BIT_SET: take = mv[ins.bsel]; // RULE3 RULE17
        OP_INCREMENT_SKIP_IF_ZERO, OP_DECREMENT_SKIP_IF_ZERO: begin
          dm_we = 1'b1; // RULE4
          dm_wd = (ins.op == OP_INCREMENT_SKIP_IF_ZERO) ? inc : dec;
          take = dm_wd == 8'h00;
        end
        OP_INCREMENT_SKIP_ZERO_ACC, OP_DECREMENT_SKIP_ZERO_ACC: begin
          acc_d = (ins.op == OP_INCREMENT_SKIP_ZERO_ACC) ? inc : dec; // RULE5
          take = acc_d == 8'h00;
        end
        OP_TRC, OP_TRL: begin
          dm_we = 1'b1; // RULE8 RULE9
          dm_wd = tword[7:0];
          thb_d = tword[PM_W-1:8];
          ncyc = 2'h2;
        end
        OP_CLR, OP_SET: begin
          dm_we = 1'b1; // RULE12
          dm_wd = (ins.op == OP_SET) ? 8'hff : 8'h00;
        end
        OP_SWAP: begin
          dm_we = 1'b1; // RULE15
          dm_wd = {mv[3:0], mv[7:4]};
        end
        OP_NIBBLE_EXCHANGE_TO_ACC: acc_d = {mv[3:0], mv[7:4]}; // RULE15
        OP_CWDT, OP_CWD1, OP_CWD2: begin
          if (wdg_clearing(ins.op, pre1_q, pre2_q)) begin
            wdg_d = '0; // RULE13 RULE14
            to_d = 1'b0;
            pdn_d = 1'b0;
            pre1_d = 1'b0;
            pre2_d = 1'b0;
          end else if (ins.op == OP_CWD1) begin
            pre1_d = 1'b1; // RULE14
          end else begin
            pre2_d = 1'b1; // RULE14
          end
        end
        OP_HALT: begin
          halt_d = 1'b1; // RULE16 RULE19
          wdg_d = '0;
          ph_d = 2'h0;
          pdn_d = 1'b1;
          to_d = 1'b0;
        end
        default: ;
      endcase
      pc_low_w = dm_we && ins.mad == `BTM_PC_LOW_ADDR;
      if (take) begin
        ncyc = ncyc + 2'h1; // RULE11
        pc_d = pc_q + 12'h002;
      end
      if (pc_low_w) begin
        ncyc = ncyc + 2'h1; // RULE10
        pc_d = {pc_q[11:8], dm_wd};
      end
      skip_d = take; // RULE20
      cnt_d = 4'(ncyc * `BTM_CPI - 1);
    end
    if (ovf) begin
      to_d = 1'b1;
      halt_d = 1'b0;
    end
    if (wr) begin
      case (addr)
        `BTM_REG_ACC: acc_d = wdata[7:0];
        `BTM_REG_DADDR: daddr_d = wdata[6:0];
        `BTM_REG_DDATA: begin
          dm_we = 1'b1;
          dm_wa = daddr_q;
          dm_wd = wdata[7:0];
        end
        `BTM_REG_PADDR: paddr_d = wdata[11:0];
        `BTM_REG_PDATA: begin
          pm_we = 1'b1;
          paddr_d = paddr_q + 12'h001;
        end
        `BTM_REG_CTRL: begin
          if (wdata[`BTM_CTRL_WAKE]) begin
            halt_d = 1'b0;
          end
        end
        default: ;
      endcase
    end
    busy_d = cnt_d != 4'h0;
    rdata_d = 32'h0;
    if (rd) begin
      case (addr)
        `BTM_REG_STATUS: begin
          rdata_d[`BTM_ST_TO] = to_q;
          rdata_d[`BTM_ST_PDN] = pdn_q;
          rdata_d[`BTM_ST_BUSY] = busy_q;
          rdata_d[`BTM_ST_HALT] = halt_q;
          rdata_d[`BTM_ST_SKIP] = skip_q;
        end
        `BTM_REG_ACC: rdata_d[7:0] = acc_q;
        `BTM_REG_PC: rdata_d[11:0] = pc_q;
        `BTM_REG_TBL_HI: rdata_d[PM_W-9:0] = thb_q;
        `BTM_REG_DADDR: rdata_d[6:0] = daddr_q;
        `BTM_REG_DDATA: rdata_d[7:0] = dmem[daddr_q];
        `BTM_REG_PADDR: rdata_d[11:0] = paddr_q;
        `BTM_REG_WDG: rdata_d[WDG_W-1:0] = wdg_q;
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // State registers
  // ----------------------------------------
  always_ff @(posedge clock) begin
    if (rst) begin
      acc_q <= `BTM_RST_ACC;
      pc_q <= `BTM_RST_PC;
      thb_q <= '0;
      to_q <= 1'b0;
      pdn_q <= 1'b0;
      halt_q <= 1'b0;
      busy_q <= 1'b0;
      skip_q <= 1'b0;
      pre1_q <= 1'b0;
      pre2_q <= 1'b0;
      cnt_q <= 4'h0;
      ph_q <= 2'h0;
      wdg_q <= '0;
      sp_q <= '0;
      daddr_q <= 7'h00;
      paddr_q <= 12'h000;
      rdata_q <= 32'h0;
    end else begin
      acc_q <= acc_d;
      pc_q <= pc_d;
      thb_q <= thb_d;
      to_q <= to_d;
      pdn_q <= pdn_d;
      halt_q <= halt_d;
      busy_q <= busy_d;
      skip_q <= skip_d;
      pre1_q <= pre1_d;
      pre2_q <= pre2_d;
      cnt_q <= cnt_d;
      ph_q <= ph_d;
      wdg_q <= wdg_d;
      sp_q <= sp_d;
      daddr_q <= daddr_d;
      paddr_q <= paddr_d;
      rdata_q <= rdata_d;
    end
  end

  always_ff @(posedge clock) begin
    if (dm_we) begin
      dmem[dm_wa] <= dm_wd;
    end
    if (pm_we) begin
      pmem[paddr_q] <= wdata[PM_W-1:0];
    end
    if (stk_we) begin
      stk[sp_q] <= pc_q + 12'h001;
    end
  end

  assign rdata = rdata_q;
  assign busy = busy_q;
  assign halted = halt_q;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  jump_timing_a: assert property (issue && ins.op == OP_UNCONDITIONAL_BRANCH |=> // RULE1
    pc_q == $past(ins.tgt) && busy_q [*7] ##1 !busy_q) else $error("jump timing");
  sz_noskip_a: assert property (issue && ins.op == OP_SKIP_IF_ZERO && mv != 8'h00 |=> // RULE2
    busy_q [*3] ##1 !busy_q) else $error("skip-if-zero base time");
  skip_extra_a: assert property (issue && take && !pc_low_w |=> // RULE11
    busy_q [*7] ##1 !busy_q) else $error("taken skip time");
  pc_low_extra_a: assert property (issue && pc_low_w && ins.op == OP_CLR |=> // RULE10
    busy_q [*7] ##1 !busy_q) else $error("pc low write time");
  swap_acc_a: assert property (issue && ins.op == OP_NIBBLE_EXCHANGE_TO_ACC |=> // RULE15
    acc_q == {$past(mv[3:0]), $past(mv[7:4])}) else $error("swap to acc");
  halt_flags_a: assert property (issue && ins.op == OP_HALT && !ovf |=> // RULE16
    halt_q && pdn_q && !to_q && wdg_q == '0) else $error("halt flags");
  wdg_clear_a: assert property (issue && ins.op == OP_CWDT && !ovf |=> // RULE13
    !to_q && !pdn_q) else $error("watchdog clear");
  preclear_a: assert property (issue && ins.op == OP_CWD1 && !pre2_q && !ovf |=> // RULE14
    to_q == $past(to_q) && pdn_q == $past(pdn_q)) else $error("lone preclear");
  squash_a: assert property (acc_cmd && skip_q |=> // RULE20
    acc_q == $past(acc_q) && pc_q == $past(pc_q) && !skip_q) else $error("squash");
  call_flags_a: assert property (issue && ins.op == OP_CALL && !ovf |=> // RULE18
    to_q == $past(to_q) && pdn_q == $past(pdn_q)) else $error("call flags");

  skip_cov_c: cover property (issue && take);
  table_cov_c: cover property (issue && ins.op == OP_TRL);
  pair_cov_c: cover property (issue && ins.op == OP_CWD1 ##[1:20] issue && ins.op == OP_CWD2);
endmodule : btm_exec

// >>> core/btm_defines.svh
// Constants for the branch, table and misc execution block
// Assumes a 100 MHz clock and an 8-bit register port address
`ifndef BTM_DEFINES_SVH
`define BTM_DEFINES_SVH
// ----------------------------------------
// Timing
// ----------------------------------------
`define BTM_CPI 4
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define BTM_REG_INSTR 8'h00
`define BTM_REG_STATUS 8'h04
`define BTM_REG_ACC 8'h08
`define BTM_REG_PC 8'h0c
`define BTM_REG_TBL_HI 8'h10
`define BTM_REG_DADDR 8'h14
`define BTM_REG_DDATA 8'h18
`define BTM_REG_PADDR 8'h1c
`define BTM_REG_PDATA 8'h20
`define BTM_REG_CTRL 8'h24
`define BTM_REG_WDG 8'h28
// ----------------------------------------
// Fields and reset values
// ----------------------------------------
`define BTM_ST_TO 0
`define BTM_ST_PDN 1
`define BTM_ST_BUSY 2
`define BTM_ST_HALT 3
`define BTM_ST_SKIP 4
`define BTM_CTRL_WAKE 0
`define BTM_PC_LOW_ADDR 7'h02
`define BTM_LAST_PAGE 4'hf
`define BTM_RST_PC 12'h000
`define BTM_RST_ACC 8'h00
`endif

// >>> core/btm_pkg.sv
// Types for the branch, table and misc execution block
// Assumes nothing beyond the defines header
package btm_pkg;
  typedef enum logic [4:0] {
    OP_NOP = 5'h00, OP_UNCONDITIONAL_BRANCH = 5'h01, OP_SKIP_IF_ZERO = 5'h02,
    OP_SKIP_IF_ZERO_TO_ACC = 5'h03, OP_SZB = 5'h04, OP_SKIP_IF_BIT_SET = 5'h05,
    OP_INCREMENT_SKIP_IF_ZERO = 5'h06, OP_DECREMENT_SKIP_IF_ZERO = 5'h07,
    OP_INCREMENT_SKIP_ZERO_ACC = 5'h08, OP_DECREMENT_SKIP_ZERO_ACC = 5'h09,
    OP_CALL = 5'h0a, OP_SUBROUTINE_EXIT = 5'h0b, OP_RETA = 5'h0c, OP_INTERRUPT_EXIT = 5'h0d,
    OP_TRC = 5'h0e, OP_TRL = 5'h0f, OP_CLR = 5'h10, OP_SET = 5'h11, OP_CWDT = 5'h12,
    OP_CWD1 = 5'h13, OP_CWD2 = 5'h14, OP_SWAP = 5'h15, OP_NIBBLE_EXCHANGE_TO_ACC = 5'h16,
    OP_HALT = 5'h17
  } btm_op_e;
  typedef struct packed {
    logic [11:0] tgt;
    logic rsv1;
    logic [2:0] bsel;
    logic rsv2;
    logic [6:0] mad;
    logic [2:0] rsv3;
    btm_op_e op;
  } btm_instr_s;
endpackage : btm_pkg

// >>> bench/tb.sv
// Self-checking bench for the branch, table and misc execution block
// Assumes btm_pkg and btm_defines.svh on the include path
`timescale 1ns/1ps
`include "btm_defines.svh"
module tb;
  import btm_pkg::*;
  // ----------------------------------------
  // Clock, reset and design
  // ----------------------------------------
  logic clock = 0;
  logic rst = 1;
  logic wr = 0;
  logic rd = 0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata;
  logic busy;
  logic halted;
  int err_total = 0;
  int total_checks = 0;
  always #5 clock = ~clock;
  // Wide watchdog so no time-out lands inside the run
  btm_exec #(.WDG_W(16)) i_btm_exec (.clock(clock), .rst(rst), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .busy(busy), .halted(halted));
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task end_sim;
    if (err_total == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : end_sim
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      err_total++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task w(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask : w
  task r(input logic [7:0] a, output logic [31:0] v);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1 v = rdata;
  endtask : r
  task rc(input string n, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] v;
    r(a, v);
    chk(n, v & m, e);
  endtask : rc
  task mem(input logic [6:0] m, input logic [7:0] v);
    w(`BTM_REG_DADDR, {25'h0, m});
    w(`BTM_REG_DDATA, {24'h0, v});
  endtask : mem
  task rm(input logic [6:0] m, input logic [7:0] e);
    w(`BTM_REG_DADDR, {25'h0, m});
    rc("dmem", `BTM_REG_DDATA, 32'hff, {24'h0, e});
  endtask : rm
  // Issue one instruction and count the clocks that busy stays high
  task is(input btm_op_e op, input logic [6:0] m, input logic [2:0] b, input logic [11:0] t,
      input int n);
    int c;
    c = 0;
    w(`BTM_REG_INSTR, {t, 1'b0, b, 1'b0, m, 3'b000, op});
    #1;
    while (busy === 1'b1 && c < 40) begin
      c++;
      @(posedge clock);
      #1;
    end
    chk("cycles", c, (n > 0) ? n * 4 - 1 : 0);
  endtask : is
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_rst;
    rc("acc", `BTM_REG_ACC, 32'hff, 32'h0);
    rc("pc", `BTM_REG_PC, 32'hfff, 32'h0);
    rc("status", `BTM_REG_STATUS, 32'h1f, 32'h0);
  endtask : t_rst
  task t_jmp;
    is(OP_UNCONDITIONAL_BRANCH, 7'h00, 3'h0, 12'h345, 2);
    rc("pc", `BTM_REG_PC, 32'hfff, 32'h345);
    rc("flags", `BTM_REG_STATUS, 32'h3, 32'h0);
  endtask : t_jmp
  task t_skip;
    logic [31:0] p;
    mem(7'h05, 8'h00);
    r(`BTM_REG_PC, p);
    is(OP_SKIP_IF_ZERO, 7'h05, 3'h0, 12'h0, 2);
    rc("pc", `BTM_REG_PC, 32'hfff, (p + 2) & 32'hfff);
    is(OP_SET, 7'h05, 3'h0, 12'h0, 0);
    rm(7'h05, 8'h00);
    rc("pend", `BTM_REG_STATUS, 32'h10, 32'h0);
    mem(7'h05, 8'h66);
    is(OP_SKIP_IF_ZERO, 7'h05, 3'h0, 12'h0, 1);
    is(OP_SKIP_IF_ZERO_TO_ACC, 7'h05, 3'h0, 12'h0, 1);
    rc("acc", `BTM_REG_ACC, 32'hff, 32'h66);
  endtask : t_skip
  task t_bits;
    mem(7'h06, 8'h10);
    for (int i = 0; i < 8; i++) begin
      is(OP_SZB, 7'h06, 3'(i), 12'h0, (i == 4) ? 1 : 2);
      if (i != 4) is(OP_NOP, 7'h06, 3'h0, 12'h0, 0);
      is(OP_SKIP_IF_BIT_SET, 7'h06, 3'(i), 12'h0, (i == 4) ? 2 : 1);
      if (i == 4) is(OP_NOP, 7'h06, 3'h0, 12'h0, 0);
    end
  endtask : t_bits
  task t_incdec;
    logic [31:0] p;
    mem(7'h07, 8'hff);
    is(OP_INCREMENT_SKIP_IF_ZERO, 7'h07, 3'h0, 12'h0, 2);
    is(OP_NOP, 7'h07, 3'h0, 12'h0, 0);
    rm(7'h07, 8'h00);
    is(OP_DECREMENT_SKIP_IF_ZERO, 7'h07, 3'h0, 12'h0, 1);
    rm(7'h07, 8'hff);
    is(OP_INCREMENT_SKIP_ZERO_ACC, 7'h07, 3'h0, 12'h0, 2);
    is(OP_NOP, 7'h07, 3'h0, 12'h0, 0);
    rc("acc", `BTM_REG_ACC, 32'hff, 32'h0);
    is(OP_DECREMENT_SKIP_ZERO_ACC, 7'h07, 3'h0, 12'h0, 1);
    rc("acc", `BTM_REG_ACC, 32'hff, 32'hfe);
    rm(7'h07, 8'hff);
    mem(`BTM_PC_LOW_ADDR, 8'h01);
    r(`BTM_REG_PC, p);
    is(OP_DECREMENT_SKIP_IF_ZERO, `BTM_PC_LOW_ADDR, 3'h0, 12'h0, 3);
    rc("pc", `BTM_REG_PC, 32'hfff, p & 32'hf00);
    is(OP_NOP, 7'h00, 3'h0, 12'h0, 0);
  endtask : t_incdec
  task t_call;
    logic [31:0] p;
    btm_op_e ro [3];
    ro = '{OP_SUBROUTINE_EXIT, OP_INTERRUPT_EXIT, OP_RETA};
    for (int k = 0; k < 3; k++) begin
      r(`BTM_REG_PC, p);
      is(OP_CALL, 7'h00, 3'h0, 12'h123, 2);
      rc("pc", `BTM_REG_PC, 32'hfff, 32'h123);
      is(ro[k], 7'h00, 3'h0, 12'h05a, 2);
      rc("pc", `BTM_REG_PC, 32'hfff, (p + 1) & 32'hfff);
      rc("flags", `BTM_REG_STATUS, 32'h3, 32'h0);
    end
    rc("acc", `BTM_REG_ACC, 32'hff, 32'h5a);
  endtask : t_call
  task t_table;
    w(`BTM_REG_ACC, 32'h33);
    w(`BTM_REG_PADDR, 32'hf33);
    w(`BTM_REG_PDATA, 32'h1abc);
    is(OP_TRL, 7'h08, 3'h0, 12'h0, 2);
    rm(7'h08, 8'hbc);
    rc("table_high", `BTM_REG_TBL_HI, 32'h7f, 32'h1a);
    is(OP_UNCONDITIONAL_BRANCH, 7'h00, 3'h0, 12'h400, 2);
    w(`BTM_REG_ACC, 32'h77);
    w(`BTM_REG_PADDR, 32'h477);
    w(`BTM_REG_PDATA, 32'h2def);
    is(OP_TRC, 7'h08, 3'h0, 12'h0, 2);
    rm(7'h08, 8'hef);
    rc("table_high", `BTM_REG_TBL_HI, 32'h7f, 32'h2d);
  endtask : t_table
  task t_misc;
    mem(7'h09, 8'h3c);
    is(OP_SWAP, 7'h09, 3'h0, 12'h0, 1);
    rm(7'h09, 8'hc3);
    is(OP_NIBBLE_EXCHANGE_TO_ACC, 7'h09, 3'h0, 12'h0, 1);
    rc("acc", `BTM_REG_ACC, 32'hff, 32'h3c);
    is(OP_CLR, 7'h09, 3'h0, 12'h0, 1);
    rm(7'h09, 8'h00);
    is(OP_SET, 7'h09, 3'h0, 12'h0, 1);
    rm(7'h09, 8'hff);
    is(OP_NOP, 7'h09, 3'h0, 12'h0, 1);
    is(OP_CLR, `BTM_PC_LOW_ADDR, 3'h0, 12'h0, 2);
  endtask : t_misc
  task t_halt(input btm_op_e op1, input btm_op_e op2);
    w(`BTM_REG_INSTR, {27'h0, OP_HALT});
    repeat (6) @(posedge clock);
    chk("halted", halted, 1'b1);
    rc("flags", `BTM_REG_STATUS, 32'h3, 32'h2);
    // Cleared at halt, then one tick per four clocks: ten clocks give two
    rc("watchdog", `BTM_REG_WDG, 32'hffff, 32'h2);
    w(`BTM_REG_CTRL, 32'h1);
    repeat (8) @(posedge clock);
    chk("halted", halted, 1'b0);
    rm(7'h09, 8'hff);
    is(op1, 7'h00, 3'h0, 12'h0, 1);
    rc("flags", `BTM_REG_STATUS, 32'h3, (op1 == OP_CWDT) ? 32'h0 : 32'h2);
    is(op2, 7'h00, 3'h0, 12'h0, 1);
    rc("flags", `BTM_REG_STATUS, 32'h3, 32'h0);
  endtask : t_halt
  // ----------------------------------------
  // Sequence and watchdog
  // ----------------------------------------
  initial begin
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    t_rst();
    t_jmp();
    t_skip();
    t_bits();
    t_incdec();
    t_call();
    t_table();
    t_misc();
    t_halt(OP_CWD1, OP_CWD2);
    t_halt(OP_CWDT, OP_NOP);
    end_sim();
  end
  initial begin
    #200000;
    err_total++;
    end_sim();
  end
endmodule : tb
